// >>> logic/rtc_pkg.sv
// Shared constants and types for the calendar clock block
package rtc_pkg;
    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_VALH = 8'h04;
    localparam logic [7:0] ADDR_VALL = 8'h08;
    localparam logic [7:0] ADDR_ISTAT = 8'h0c;
    localparam logic [7:0] ADDR_ICLR = 8'h10;
    localparam logic [7:0] ADDR_IEN = 8'h14;
    localparam logic [7:0] ADDR_OSEL = 8'h18;
    localparam logic [7:0] ADDR_ALRM = 8'h1c;
    // ==========================================================
    // Configuration field positions
    localparam int POS_EN = 15;
    localparam int POS_WREN = 13;
    localparam int POS_SYNC = 12;
    localparam int POS_HALF = 11;
    localparam int POS_OE = 10;
    localparam int POS_PTR = 8;
    localparam int CAL_W = 8;
    localparam logic [CAL_W-1:0] CAL_RST = 8'h00;
    // ==========================================================
    // Window pointer codes
    localparam logic [1:0] PTR_MIN_SEC = 2'b00;
    localparam logic [1:0] PTR_PTR_RST = 2'b00;
    // ==========================================================
    // Timing
    localparam int CLK_NS = 20;
    localparam int HALF_SEC_NS = 500000000;
    localparam int HALF_SEC_CYC = HALF_SEC_NS / CLK_NS;
    localparam int RIPPLE_NS = 100;
    localparam int RIPPLE_CYC = (RIPPLE_NS + CLK_NS - 1) / CLK_NS;
    // ==========================================================
    // BCD limits and reset date (Saturday 2000-01-01)
    localparam logic [7:0] BCD_59 = 8'h59;
    localparam logic [7:0] BCD_23 = 8'h23;
    localparam logic [7:0] BCD_12 = 8'h12;
    localparam logic [7:0] BCD_99 = 8'h99;
    localparam logic [7:0] BCD_00 = 8'h00;
    localparam logic [7:0] BCD_01 = 8'h01;
    localparam logic [7:0] WD_LAST = 8'h06;
    localparam logic [7:0] WD_RST = 8'h06;
    // ==========================================================
    // Interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_HALF = 0;
    localparam int IRQ_SEC = 1;
    localparam int IRQ_ALRM = 2;
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] weekday;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } cal_time_t;
    localparam cal_time_t TIME_RST = '{BCD_00, BCD_01, BCD_01, WD_RST, BCD_00, BCD_00, BCD_00};
endpackage

// >>> logic/calendar_clock_control.sv
// Calendar clock with configuration, value window, alarm and APB slave
`timescale 1ns/1ns
`default_nettype none
module calendar_clock_control
    import rtc_pkg::*;
#(
    parameter int HALF_CYCLES = HALF_SEC_CYC
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic irq_out,
    output logic tick_pin_out
);
    // ==========================================================
    // BCD helpers
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction

    function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            8'h02: last_day = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
            default: last_day = 8'h31;
        endcase
    endfunction

    // ==========================================================
    // State
    logic en_r, wren_r, oe_r, half_r, pready_r, pslverr_r, irq_r, pin_r, osel_r, alrm_r;
    logic [1:0] ptr_r;
    logic [CAL_W-1:0] cal_r;
    logic [31:0] prdata_r, div_r, term;
    logic [15:0] alarm_r;
    logic [IRQ_W-1:0] ist_r, ien_r, ev;
    cal_time_t time_r, time_nxt, time_adv;
    logic setup, acc, wr, rd, mapped, tick, sec_tick, sync, valw, lowclr, hit;

    // APB phase decode
    assign setup = psel_in & ~penable_in;
    assign acc = psel_in & penable_in & pready_r;
    assign wr = acc & pwrite_in;
    assign rd = acc & ~pwrite_in;
    assign mapped = (paddr_in[1:0] == 2'b00) && (paddr_in <= ADDR_ALRM);
    assign valw = wr && (paddr_in == ADDR_VALH || paddr_in == ADDR_VALL);
    assign lowclr = valw && ptr_r == PTR_MIN_SEC && pstrb_in[0];

    // One-cycle access phase, error on unmapped addresses
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & ~mapped;
        end
    end

    // Window field pair selected by pointer
    function automatic logic [15:0] win(input cal_time_t t, input logic [1:0] p);
        case (p)
            2'b00: win = {t.minutes, t.seconds};
            2'b01: win = {t.weekday, t.hours};
            2'b10: win = {t.month, t.day};
            default: win = {BCD_00, t.year};
        endcase
    endfunction

    // Read data captured in the setup cycle
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prdata_r <= '0;
        end else if (setup && !pwrite_in) begin
            prdata_r <= '0;
            case (paddr_in)
                ADDR_CFG: prdata_r[15:0] <= {en_r, 1'b0, wren_r, sync, half_r, oe_r,
                                             ptr_r, cal_r};
                ADDR_VALH, ADDR_VALL: prdata_r[15:0] <= win(time_r, ptr_r);
                ADDR_ISTAT: prdata_r[IRQ_W-1:0] <= ist_r;
                ADDR_IEN: prdata_r[IRQ_W-1:0] <= ien_r;
                ADDR_OSEL: prdata_r[0] <= osel_r;
                ADDR_ALRM: prdata_r[15:0] <= alarm_r;
                default: prdata_r <= '0;
            endcase
        end
    end

    // Configuration register; only the power-on reset reaches it
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            en_r <= 1'b0;
            wren_r <= 1'b0;
            oe_r <= 1'b0;
            cal_r <= CAL_RST;
        end else if (wr && paddr_in == ADDR_CFG) begin
            if (pstrb_in[1]) begin
                if (wren_r) begin
                    en_r <= pwdata_in[POS_EN];
                end
                wren_r <= pwdata_in[POS_WREN];
                oe_r <= pwdata_in[POS_OE];
            end
            if (pstrb_in[0]) begin
                cal_r <= pwdata_in[CAL_W-1:0];
            end
        end
    end

    // Window pointer: load, or step down on high window access
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ptr_r <= PTR_PTR_RST;
        end else if (wr && paddr_in == ADDR_CFG && pstrb_in[1]) begin
            ptr_r <= pwdata_in[POS_PTR +: 2];
        end else if (acc && paddr_in == ADDR_VALH && ptr_r != PTR_MIN_SEC) begin
            ptr_r <= ptr_r - 2'b01;
        end
    end

    // Other software registers
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ien_r <= '0;
            osel_r <= 1'b0;
            alarm_r <= '0;
        end else if (wr) begin
            if (paddr_in == ADDR_IEN) ien_r <= pwdata_in[IRQ_W-1:0];
            if (paddr_in == ADDR_OSEL) osel_r <= pwdata_in[0];
            if (paddr_in == ADDR_ALRM) alarm_r <= pwdata_in[15:0];
        end
    end

    // ==========================================================
    // Half-second divider with calibration once per minute
    always_comb begin
        term = 32'(HALF_CYCLES - 1);
        if (time_r.seconds == BCD_00 && !half_r) begin
            term = 32'(HALF_CYCLES - 1) - {{(32-CAL_W){cal_r[CAL_W-1]}}, cal_r};
        end
    end
    assign tick = en_r && div_r >= term;
    assign sec_tick = tick && half_r;
    assign sync = en_r && half_r && (div_r + 32'(RIPPLE_CYC) >= term);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            div_r <= '0;
            half_r <= 1'b0;
        end else if (lowclr) begin
            div_r <= '0;
            half_r <= 1'b0;
        end else if (tick) begin
            div_r <= '0;
            half_r <= ~half_r;
        end else if (en_r) begin
            div_r <= div_r + 32'd1;
        end
    end

    // ==========================================================
    // Calendar advance on each full second
    always_comb begin
        time_adv = time_r;
        if (time_r.seconds != BCD_59) begin
            time_adv.seconds = bcd_inc(time_r.seconds);
        end else begin
            time_adv.seconds = BCD_00;
            if (time_r.minutes != BCD_59) begin
                time_adv.minutes = bcd_inc(time_r.minutes);
            end else begin
                time_adv.minutes = BCD_00;
                if (time_r.hours != BCD_23) begin
                    time_adv.hours = bcd_inc(time_r.hours);
                end else begin
                    time_adv.hours = BCD_00;
                    time_adv.weekday = (time_r.weekday == WD_LAST) ? BCD_00
                                       : time_r.weekday + 8'h01;
                    if (time_r.day < last_day(time_r.month, time_r.year)) begin
                        time_adv.day = bcd_inc(time_r.day);
                    end else begin
                        time_adv.day = BCD_01;
                        if (time_r.month != BCD_12) begin
                            time_adv.month = bcd_inc(time_r.month);
                        end else begin
                            time_adv.month = BCD_01;
                            time_adv.year = (time_r.year == BCD_99) ? BCD_00
                                            : bcd_inc(time_r.year);
                        end
                    end
                end
            end
        end
    end

    // Unlocked window writes override counting
    always_comb begin
        time_nxt = sec_tick ? time_adv : time_r;
        if (valw && wren_r) begin
            case (ptr_r)
                2'b00: begin
                    if (pstrb_in[1]) time_nxt.minutes = pwdata_in[15:8];
                    if (pstrb_in[0]) time_nxt.seconds = pwdata_in[7:0];
                end
                2'b01: begin
                    if (pstrb_in[1]) time_nxt.weekday = pwdata_in[15:8];
                    if (pstrb_in[0]) time_nxt.hours = pwdata_in[7:0];
                end
                2'b10: begin
                    if (pstrb_in[1]) time_nxt.month = pwdata_in[15:8];
                    if (pstrb_in[0]) time_nxt.day = pwdata_in[7:0];
                end
                default: begin
                    if (pstrb_in[0]) time_nxt.year = pwdata_in[7:0];
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            time_r <= TIME_RST;
        end else begin
            time_r <= time_nxt;
        end
    end

    // ==========================================================
    // Alarm match, output pin and interrupts
    assign hit = sec_tick && {time_adv.minutes, time_adv.seconds} == alarm_r;
    assign ev = {hit, sec_tick, tick};

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            alrm_r <= 1'b0;
            pin_r <= 1'b0;
        end else begin
            if (hit) alrm_r <= 1'b1;
            else if (tick) alrm_r <= 1'b0;
            pin_r <= oe_r & (osel_r ? alrm_r : (en_r & ~half_r));
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ist_r <= '0;
            irq_r <= 1'b0;
        end else begin
            if (wr && paddr_in == ADDR_ICLR) ist_r <= (ist_r & ~pwdata_in[IRQ_W-1:0]) | ev;
            else ist_r <= ist_r | ev;
            irq_r <= |(ist_r & ien_r);
        end
    end

    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign irq_out = irq_r;
    assign tick_pin_out = pin_r;

    // ==========================================================
    // Checks
    chk_enable_lock: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr && paddr_in == ADDR_CFG && !wren_r) |=> en_r == $past(en_r))
        else $error("enable changed while locked");
    chk_value_lock: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (valw && !wren_r && !sec_tick) |=> time_r == $past(time_r))
        else $error("locked window write took effect");
    chk_bit14_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rd && paddr_in == ADDR_CFG) |-> prdata_out[14] == 1'b0)
        else $error("unimplemented bit read as one");
    chk_ptr_step: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (acc && paddr_in == ADDR_VALH && ptr_r != 2'b00)
        |=> ptr_r == $past(ptr_r) - 2'b01)
        else $error("pointer did not step down");
    chk_ptr_floor: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (acc && paddr_in == ADDR_VALH && ptr_r == 2'b00) |=> ptr_r == 2'b00)
        else $error("pointer left zero");
    chk_half_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        lowclr |=> !half_r ##1 (!half_r || $past(tick)))
        else $error("half phase not cleared");
    chk_hour_range: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (time_r.hours == BCD_23 && time_r.minutes == BCD_59 && time_r.seconds == BCD_59
         && sec_tick && !valw) |=> time_r.hours == BCD_00 && time_r.seconds == BCD_00)
        else $error("hours did not wrap to zero");
    chk_disabled_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!en_r && !valw && !lowclr) |=> div_r == $past(div_r) && time_r == $past(time_r))
        else $error("counting while disabled");
    chk_pin_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !oe_r |=> !tick_pin_out)
        else $error("pin active while output disabled");
    chk_irq_level: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        |(ist_r & ien_r) |=> irq_out)
        else $error("interrupt not raised");
endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking testbench for the calendar clock control block
`timescale 1ns/1ns
`default_nettype none
module tb
    import rtc_pkg::*;
;
    localparam int HC = 8;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [3:0] pstrb_in = 4'h0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic irq_out;
    logic tick_pin_out;
    int error_cnt = 0;
    int num_checks = 0;
    // ==========================================================
    // Design under test with a short half-second
    calendar_clock_control #(.HALF_CYCLES(HC)) dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out),
        .tick_pin_out(tick_pin_out)
    );
    // Clock at 50 MHz
    always #10 clk_in = ~clk_in;
    // ==========================================================
    // Common tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        pstrb_in <= s;
        @(posedge clk_in);
        penable_in <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_in);
        end while (pready_out !== 1'b1);
        r = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, 4'h0, d, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, 4'h3, r, e);
    endtask
    // Read until the masked value appears, bounded
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        logic [31:0] d;
        int n;
        n = 0;
        do begin
            rd(a, d);
            n++;
        end while ((d & m) !== v && n < 60);
        chk(d & m, v);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_lock();
        logic [31:0] d;
        rd(ADDR_CFG, d); chk(d, 32'h0);
        wr(ADDR_CFG, 32'h8300);
        rd(ADDR_CFG, d); chk(d, 32'h0300);
        wr(ADDR_VALH, 32'h0099);
        rd(ADDR_CFG, d); chk(d, 32'h0200);
        rd(ADDR_VALH, d); chk(d, 32'h0101);
        rd(ADDR_VALH, d); chk(d, 32'h0600);
        rd(ADDR_VALH, d); chk(d, 32'h0000);
        rd(ADDR_CFG, d); chk(d, 32'h0000);
        wr(ADDR_CFG, 32'h0300);
        rd(ADDR_VALL, d); chk(d, 32'h0000);
        wr(ADDR_CFG, 32'h2000);
        wr(ADDR_CFG, 32'ha000);
        rd(ADDR_CFG, d); chk(d & ~32'h1800, 32'ha000);
        wr(ADDR_CFG, 32'h2000);
        rd(ADDR_CFG, d); chk(d, 32'h2000);
    endtask
    // Last second of February 28 rolls into the next day
    task automatic t_date(input logic [7:0] yr, input logic [15:0] md);
        logic [31:0] d;
        wr(ADDR_CFG, 32'h2300);
        wr(ADDR_VALH, {24'h0, yr});
        wr(ADDR_VALH, 32'h0228);
        wr(ADDR_VALH, 32'h0323);
        wr(ADDR_VALH, 32'h5959);
        wr(ADDR_CFG, 32'ha000);
        poll(ADDR_VALH, 32'hffff, 32'h0000);
        poll(ADDR_CFG, 32'h1000, 32'h0000);
        wr(ADDR_CFG, 32'h2200);
        rd(ADDR_VALH, d); chk(d, {16'h0, md});
        rd(ADDR_VALH, d); chk(d, 32'h0400);
        wr(ADDR_CFG, 32'h2300);
        rd(ADDR_VALL, d); chk(d, {24'h0, yr});
    endtask
    task automatic t_half();
        logic [31:0] d;
        logic e;
        wr(ADDR_CFG, 32'ha000);
        poll(ADDR_CFG, 32'h1000, 32'h1000);
        poll(ADDR_CFG, 32'h0800, 32'h0800);
        apb(1'b1, ADDR_VALL, 32'h0, 4'h1, d, e);
        rd(ADDR_CFG, d); chk(d & 32'h0800, 32'h0);
    endtask
    task automatic t_irq();
        logic [31:0] d;
        int n;
        wr(ADDR_IEN, 32'h1 << IRQ_SEC);
        for (n = 0; n < 60 && irq_out !== 1'b1; n++) @(posedge clk_in);
        chk(irq_out, 1'b1);
        wr(ADDR_CFG, 32'h2000);
        rd(ADDR_ISTAT, d); chk(d[IRQ_SEC], 1'b1);
        wr(ADDR_ICLR, 32'h7);
        rd(ADDR_ISTAT, d); chk(d, 32'h0);
        chk(irq_out, 1'b0);
        wr(ADDR_IEN, 32'h0);
        wr(ADDR_CFG, 32'ha000);
        poll(ADDR_ISTAT, 32'h2, 32'h2);
        chk(irq_out, 1'b0);
    endtask
    task automatic t_pin();
        logic s;
        int n;
        s = 1'b0;
        repeat (40) begin
            @(posedge clk_in);
            if (tick_pin_out !== 1'b0) s = 1'b1;
        end
        chk(s, 1'b0);
        wr(ADDR_CFG, 32'ha400);
        for (n = 0; n < 40 && tick_pin_out !== 1'b1; n++) @(posedge clk_in);
        chk(tick_pin_out, 1'b1);
        // Positive trim shortens the first half-second of the minute
        wr(ADDR_CFG, 32'ha402);
        wr(ADDR_VALH, 32'h0000);
        repeat (2) @(posedge clk_in);
        for (n = 0; n < 20 && tick_pin_out === 1'b1; n++) @(posedge clk_in);
        chk(n, HC - 2);
        wr(ADDR_CFG, 32'ha400);
        wr(ADDR_OSEL, 32'h1);
        wr(ADDR_ALRM, 32'h0002);
        wr(ADDR_VALH, 32'h0000);
        for (n = 0; n < 80 && tick_pin_out !== 1'b1; n++) @(posedge clk_in);
        chk(tick_pin_out, 1'b1);
    endtask
    task automatic t_misc();
        logic [31:0] d;
        logic e;
        apb(1'b0, 8'h20, 32'h0, 4'h0, d, e);
        chk({d[30:0], e}, 32'h1);
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(ADDR_CFG, d); chk(d, 32'h0);
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_lock();
        t_date(8'h99, 16'h0301);
        t_date(8'h00, 16'h0229);
        t_half();
        t_irq();
        t_pin();
        t_misc();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
